// ===== rtl/jap_pkg.sv
// Purpose: shared constants and types of the scan-port access protection block
// Assumes: 8-bit instruction register, 16-bit data registers on the scan port
// Notes:   instruction encodings are local choices; the memory locations are informational
package jap_pkg;

   // ----------------------------------------------------------------
   // scan register geometry
   // ----------------------------------------------------------------
   localparam int IR_W = 8;
   localparam int DR_W = 16;

   // ----------------------------------------------------------------
   // instruction encodings
   // ----------------------------------------------------------------
   localparam logic [IR_W-1:0] INSTR_BYPASS       = 8'hFF;
   localparam logic [IR_W-1:0] INSTR_CTRL_SELECT  = 8'h13;
   localparam logic [IR_W-1:0] INSTR_CTRL_CAPTURE = 8'h14;
   localparam logic [IR_W-1:0] INSTR_FUSE_PREPARE = 8'h22;
   localparam logic [IR_W-1:0] INSTR_FUSE_FIRE    = 8'h24;
   localparam logic [IR_W-1:0] INSTR_BOR_TRIGGER  = 8'h30;

   // ----------------------------------------------------------------
   // data values and memory locations
   // ----------------------------------------------------------------
   localparam logic [DR_W-1:0] CTRL_TDO_AS_TDI    = 16'h7201;
   localparam logic [DR_W-1:0] CTRL_RESET_VALUE   = 16'h0000;
   localparam logic [15:0]     LOCK_ADDR_FIRST    = 16'h17FC;
   localparam logic [15:0]     LOCK_ADDR_LAST     = 16'h17FF;
   localparam logic [15:0]     SECURE_WORD_ADDR   = 16'hFF80;
   localparam logic [31:0]     LOCK_ALL_ZERO      = 32'h00000000;
   localparam logic [31:0]     LOCK_ALL_ONE       = 32'hFFFFFFFF;
   localparam logic [31:0]     SECURE_PATTERN     = 32'h55555555;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int BOR_PULSE_CYCLES = 4;
   localparam int BOR_CNT_W        = 3;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic tms;
      logic tdi;
      logic tdoIn;
   } jap_scan_in_s;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE,
      TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
      TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } jap_tap_e;

endpackage : jap_pkg

// ===== rtl/jap_sync.sv
// Purpose: two flip-flop synchroniser for levels and toggles
// Assumes: input bits are independent levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module jap_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstN,
   input  wire logic [W-1:0] dIn,
   output logic      [W-1:0] dOut
);
   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;

   // ----------------------------------------------------------------
   // double register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= dIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign dOut = stage2_reg;

endmodule : jap_sync

// ===== rtl/jap_access_protect.sv
// Purpose: scan-port access protection: fuse burn, lock signature, secure modes, bypass-only port
// Assumes: tck is the host's scan clock; memory words arrive already read on sys_clk
// Notes:   protection is decided once per boot; the password gate alone is live
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - shared-pin parts talk on the scan port only while the enable pin is high
// RULE2 - during fuse programming the serial data input is taken from the TDO pin
// RULE3 - control register loaded with 0x7201 swaps the data input onto TDO
// RULE4 - host shifts prepare, waits 1 ms, applies voltage, waits for settling
// RULE5 - host shifts fire, waits 1 ms, removes voltage, restores TDI, resets TAP
// RULE6 - shared-pin parts follow the same order with voltage on the enable pin
// RULE7 - two-wire fuse programming happens while the TAP sits in Run-Test/Idle
// RULE8 - two-wire host adds one mode-select slot after fire before applying voltage
// RULE9 - two-wire data rising after voltage settles blows the fuse
// RULE10 - two-wire host holds data low when leaving the fire instruction shift
// RULE11 - lock words other than all zeros or all ones lock the port for good
// RULE12 - host clears the loader write-protect bit before programming the signature
// RULE13 - signature is evaluated and protection armed only at boot after brownout
// RULE14 - a write to the brownout data register raises a brownout reset
// RULE15 - brownout reset also resets the scan logic, releasing scan control
// RULE16 - secure pattern in the protection word denies scan access after brownout
// RULE17 - protected mode refuses scan access without the correct password
// RULE18 - once protected and reset, only bypass is offered
// RULE19 - bypass passes data input to TDO delayed by exactly one scan clock
// RULE20 - host tests protection by shifting 0xaaaa and expecting 0x5555 back
module jap_access_protect
   import jap_pkg::*;
#(
   parameter int BOR_CYCLES = BOR_PULSE_CYCLES
) (
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  tck,
   input  wire jap_pkg::jap_scan_in_s scanIn,
   input  wire logic                  scanEnable,
   input  wire logic                  twoWireMode,
   input  wire logic                  twoWireData,
   input  wire logic                  vppSettled,
   input  wire logic                  fuseIntact,
   input  wire logic [31:0]           lockWord,
   input  wire logic [31:0]           secureWord,
   input  wire logic                  protectedMode,
   input  wire logic                  passwordOk,
   output logic                       tdoOut,
   output logic                       tdoOe,
   output logic                       fuseBlow,
   output logic                       brownoutReset,
   output logic                       scanLocked
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic jap_tap_e tapStep(input jap_tap_e s, input logic tms);
      case (s)
         TAP_RESET:    tapStep = tms ? TAP_RESET    : TAP_IDLE;
         TAP_IDLE:     tapStep = tms ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_DR:   tapStep = tms ? TAP_SEL_IR   : TAP_CAP_DR;
         TAP_CAP_DR:   tapStep = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: tapStep = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: tapStep = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
         TAP_PAUSE_DR: tapStep = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: tapStep = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
         TAP_UPD_DR:   tapStep = tms ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_IR:   tapStep = tms ? TAP_RESET    : TAP_CAP_IR;
         TAP_CAP_IR:   tapStep = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: tapStep = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: tapStep = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
         TAP_PAUSE_IR: tapStep = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: tapStep = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
         TAP_UPD_IR:   tapStep = tms ? TAP_SEL_DR   : TAP_IDLE;
         default:      tapStep = TAP_RESET;
      endcase
   endfunction : tapStep

   function automatic logic lockSignatureSet(input logic [31:0] w);
      lockSignatureSet = (w != LOCK_ALL_ZERO) && (w != LOCK_ALL_ONE);
   endfunction : lockSignatureSet

   // ----------------------------------------------------------------
   // crossings
   // ----------------------------------------------------------------
   logic                 brownoutReset_reg, brownoutReset_next;
   logic [BOR_CNT_W-1:0] borCnt_reg, borCnt_next;
   logic                 borSeen_reg, borSeen_next;
   logic                 evalPending_reg, evalPending_next;
   logic                 bootLock_reg, bootLock_next;
   logic                 scanLocked_reg, scanLocked_next;
   logic       tapRstN;
   logic       borToggle_reg;
   logic       fireReady_reg;
   logic [3:0] sysSyncOut;
   logic [1:0] tckSyncOut;
   logic       borToggleSys;
   logic       fireReadySys;
   logic       vppSys;
   logic       dataSys;
   logic       fuseIntactSys;
   logic       lockedTck;
   logic       enableTck;

   // a brownout holds the whole scan side in reset, which drops host control
   assign tapRstN = resetn & ~brownoutReset_reg; // RULE15

   jap_sync #(.W(4)) u_sys_sync (
      .clk  (sys_clk),
      .rstN (resetn),
      .dIn  ({borToggle_reg, fireReady_reg, vppSettled, twoWireData}),
      .dOut (sysSyncOut)
   );

   jap_sync #(.W(1)) u_fuse_sync (
      .clk  (sys_clk),
      .rstN (resetn),
      .dIn  (fuseIntact),
      .dOut (fuseIntactSys)
   );

   jap_sync #(.W(2)) u_tck_sync (
      .clk  (tck),
      .rstN (tapRstN),
      .dIn  ({scanLocked_reg, scanEnable}),
      .dOut (tckSyncOut)
   );

   assign borToggleSys = sysSyncOut[3];
   assign fireReadySys = sysSyncOut[2];
   assign vppSys       = sysSyncOut[1];
   assign dataSys      = sysSyncOut[0];
   assign lockedTck    = tckSyncOut[1];
   assign enableTck    = tckSyncOut[0];

   // ----------------------------------------------------------------
   // brownout generation and boot evaluation (sys_clk)
   // ----------------------------------------------------------------
   always_comb begin
      brownoutReset_next = brownoutReset_reg;
      borCnt_next        = borCnt_reg;
      borSeen_next       = borToggleSys;
      evalPending_next   = evalPending_reg;
      bootLock_next      = bootLock_reg;
      // the request is cleared by the brownout it raises, so only its rise counts
      if (borToggleSys && !borSeen_reg) begin
         brownoutReset_next = 1'b1; // RULE14
         borCnt_next        = BOR_CNT_W'(BOR_CYCLES - 1);
         evalPending_next   = 1'b1;
      end else if (brownoutReset_reg) begin
         if (borCnt_reg == '0) begin
            brownoutReset_next = 1'b0;
         end else begin
            borCnt_next = borCnt_reg - 1'b1;
         end
      end else if (evalPending_reg) begin
         // decided once per boot; later memory changes wait for the next brownout
         // after resetn the fuse synchroniser needs two edges before it is valid
         if (borCnt_reg != '0) begin
            borCnt_next = borCnt_reg - 1'b1;
         end else begin
            bootLock_next    = ~fuseIntactSys | lockSignatureSet(lockWord) |
                               (secureWord == SECURE_PATTERN); // RULE11 RULE13 RULE16
            evalPending_next = 1'b0;
         end
      end
      scanLocked_next = bootLock_reg | (protectedMode & ~passwordOk); // RULE17 RULE18
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         brownoutReset_reg <= 1'b0;
         borCnt_reg        <= 3'h2;
         borSeen_reg       <= 1'b0;
         evalPending_reg   <= 1'b1;
         bootLock_reg      <= 1'b0;
         scanLocked_reg    <= 1'b0;
      end else begin
         brownoutReset_reg <= brownoutReset_next;
         borCnt_reg        <= borCnt_next;
         borSeen_reg       <= borSeen_next;
         evalPending_reg   <= evalPending_next;
         bootLock_reg      <= bootLock_next;
         scanLocked_reg    <= scanLocked_next;
      end
   end

   // ----------------------------------------------------------------
   // fuse burn strobe (sys_clk)
   // ----------------------------------------------------------------
   logic fuseBlow_reg, fuseBlow_next;
   logic dataPrev_reg, dataPrev_next;

   // the scan clock may carry the voltage in two-wire mode, so the burn is timed here
   always_comb begin
      dataPrev_next = dataSys;
      fuseBlow_next = 1'b0;
      if (fireReadySys && vppSys) begin
         if (twoWireMode) begin
            fuseBlow_next = fuseBlow_reg | (dataSys & ~dataPrev_reg); // RULE7 RULE9
         end else begin
            fuseBlow_next = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fuseBlow_reg <= 1'b0;
         dataPrev_reg <= 1'b0;
      end else begin
         fuseBlow_reg <= fuseBlow_next;
         dataPrev_reg <= dataPrev_next;
      end
   end

   // ----------------------------------------------------------------
   // TAP and scan registers (tck rising)
   // ----------------------------------------------------------------
   jap_tap_e        tap_reg, tap_next;
   logic [IR_W-1:0] irShift_reg, irShift_next;
   logic [IR_W-1:0] ir_reg, ir_next;
   logic [DR_W-1:0] drShift_reg, drShift_next;
   logic [DR_W-1:0] ctrl_reg, ctrl_next;
   logic            bypass_reg, bypass_next;
   logic            dataFromTdo_reg, dataFromTdo_next;
   logic            armed_reg, armed_next;
   logic            borToggle_next;
   logic            fireReady_next;
   logic            tdiEff;
   logic [IR_W-1:0] instr;

   assign tdiEff = dataFromTdo_reg ? scanIn.tdoIn : scanIn.tdi; // RULE2
   // a locked port decodes everything as bypass
   assign instr = lockedTck ? INSTR_BYPASS : ir_reg; // RULE18

   always_comb begin
      tap_next         = enableTck ? tapStep(tap_reg, scanIn.tms) : TAP_RESET; // RULE1
      irShift_next     = irShift_reg;
      ir_next          = ir_reg;
      drShift_next     = drShift_reg;
      ctrl_next        = ctrl_reg;
      bypass_next      = bypass_reg;
      dataFromTdo_next = dataFromTdo_reg;
      armed_next       = armed_reg;
      borToggle_next   = borToggle_reg;
      case (tap_reg)
         TAP_RESET: begin
            ir_next          = INSTR_BYPASS;
            dataFromTdo_next = 1'b0;
            armed_next       = 1'b0;
         end
         TAP_CAP_IR: begin
            irShift_next = ir_reg;
         end
         TAP_SHIFT_IR: begin
            irShift_next = {tdiEff, irShift_reg[IR_W-1:1]};
         end
         TAP_UPD_IR: begin
            ir_next = irShift_reg;
            if (irShift_reg == INSTR_FUSE_PREPARE && !lockedTck) begin
               armed_next = 1'b1;
            end
         end
         TAP_CAP_DR: begin
            drShift_next = ctrl_reg;
            bypass_next  = 1'b0;
         end
         TAP_SHIFT_DR: begin
            drShift_next = {tdiEff, drShift_reg[DR_W-1:1]};
            bypass_next  = tdiEff; // RULE19
         end
         TAP_UPD_DR: begin
            if (instr == INSTR_CTRL_SELECT) begin
               ctrl_next        = drShift_reg;
               dataFromTdo_next = (drShift_reg == CTRL_TDO_AS_TDI); // RULE3
            end
            if (instr == INSTR_BOR_TRIGGER) begin
               borToggle_next = 1'b1; // RULE14
            end
         end
         default: begin
         end
      endcase
      // burn window: fire loaded after prepare, TAP parked in Run-Test/Idle
      fireReady_next = armed_reg && !lockedTck && (ir_next == INSTR_FUSE_FIRE) && (tap_next == TAP_IDLE); // RULE7
   end

   always_ff @(posedge tck or negedge tapRstN) begin
      if (!tapRstN) begin
         tap_reg         <= TAP_RESET;
         irShift_reg     <= '0;
         ir_reg          <= INSTR_BYPASS;
         drShift_reg     <= '0;
         ctrl_reg        <= CTRL_RESET_VALUE;
         bypass_reg      <= 1'b0;
         dataFromTdo_reg <= 1'b0;
         armed_reg       <= 1'b0;
         borToggle_reg   <= 1'b0;
         fireReady_reg   <= 1'b0;
      end else begin
         tap_reg         <= tap_next;
         irShift_reg     <= irShift_next;
         ir_reg          <= ir_next;
         drShift_reg     <= drShift_next;
         ctrl_reg        <= ctrl_next;
         bypass_reg      <= bypass_next;
         dataFromTdo_reg <= dataFromTdo_next;
         armed_reg       <= armed_next;
         borToggle_reg   <= borToggle_next;
         fireReady_reg   <= fireReady_next;
      end
   end

   // ----------------------------------------------------------------
   // TDO driver (tck falling)
   // ----------------------------------------------------------------
   logic tdoOut_reg, tdoOut_next;
   logic tdoOe_reg, tdoOe_next;
   logic drSelected;

   assign drSelected = (instr == INSTR_CTRL_SELECT) || (instr == INSTR_CTRL_CAPTURE);

   always_comb begin
      tdoOut_next = 1'b0;
      if (tap_reg == TAP_SHIFT_IR) begin
         tdoOut_next = irShift_reg[0];
      end else if (tap_reg == TAP_SHIFT_DR) begin
         tdoOut_next = drSelected ? drShift_reg[0] : bypass_reg; // RULE19
      end
      // the pin turns into an input while the data input is swapped onto it
      tdoOe_next = enableTck && !dataFromTdo_reg &&
                   ((tap_reg == TAP_SHIFT_IR) || (tap_reg == TAP_SHIFT_DR)); // RULE1 RULE2
   end

   always_ff @(negedge tck or negedge tapRstN) begin
      if (!tapRstN) begin
         tdoOut_reg <= 1'b0;
         tdoOe_reg  <= 1'b0;
      end else begin
         tdoOut_reg <= tdoOut_next;
         tdoOe_reg  <= tdoOe_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign tdoOut        = tdoOut_reg;
   assign tdoOe         = tdoOe_reg;
   assign fuseBlow      = fuseBlow_reg;
   assign brownoutReset = brownoutReset_reg;
   assign scanLocked    = scanLocked_reg;

endmodule : jap_access_protect

// ===== tb/jap_access_protect_monitor.sv
// Purpose: port checker for the scan-port access protection block
// Assumes: the bench holds lock inputs steady across each boot
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module jap_access_protect_monitor
   import jap_pkg::*;
#(
   parameter int BOR_CYCLES = BOR_PULSE_CYCLES
) (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        tck,
   input wire logic        scanEnable,
   input wire logic        twoWireMode,
   input wire logic        twoWireData,
   input wire logic        vppSettled,
   input wire logic        fuseIntact,
   input wire logic [31:0] lockWord,
   input wire logic [31:0] secureWord,
   input wire logic        protectedMode,
   input wire logic        passwordOk,
   input wire logic        tdoOe,
   input wire logic        fuseBlow,
   input wire logic        brownoutReset,
   input wire logic        scanLocked
);
   logic [3:0] borLenReg, borLenNext;
   logic [2:0] bootAgeReg, bootAgeNext;
   logic       lockExpect;
   // boot age saturates so a late change of scanLocked stays visible
   assign lockExpect = (lockWord != LOCK_ALL_ZERO && lockWord != LOCK_ALL_ONE) || secureWord == SECURE_PATTERN
                       || !fuseIntact;
   always_comb begin
      borLenNext = brownoutReset ? borLenReg + 4'h1 : 4'h0;
      bootAgeNext = brownoutReset ? 3'h0 : (bootAgeReg == 3'h7 ? 3'h7 : bootAgeReg + 3'h1);
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         borLenReg <= 4'h0;
         bootAgeReg <= 3'h0;
      end else begin
         borLenReg <= borLenNext;
         bootAgeReg <= bootAgeNext;
      end
   end
   bor_width_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $fell(brownoutReset) |-> borLenReg == BOR_CYCLES) else $error("brownout pulse length wrong");
   boot_lock_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (($rose(resetn) ##2 !protectedMode) or ($fell(brownoutReset) && !protectedMode)) |-> ##2 scanLocked == lockExpect)
      else $error("lock state after boot wrong");
   live_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $changed(scanLocked) && !protectedMode |-> bootAgeReg < 3'h6) else $error("lock changed outside boot");
   bor_release_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      brownoutReset |-> !tdoOe) else $error("scan port driven during brownout");
   bor_refused_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(brownoutReset) |-> !$past(scanLocked)) else $error("brownout accepted while locked");
   pass_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (protectedMode && !passwordOk)[*3] |-> scanLocked) else $error("protected mode not refusing");
   wire_blow_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      twoWireMode && fuseBlow |-> $past(vppSettled, 3) && $past(twoWireData, 3)) else $error("two-wire blow early");
   fuse_locked_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      fuseBlow |-> !scanLocked) else $error("fuse blow while locked");
   scan_gate_a: assert property (@(posedge tck) disable iff (!resetn)
      !scanEnable[*4] |=> !tdoOe) else $error("scan port active with enable low");
endmodule : jap_access_protect_monitor

bind jap_access_protect jap_access_protect_monitor #(.BOR_CYCLES(BOR_CYCLES)) mon (.*);

// ===== tb/jap_host_model.sv
// Purpose: scan host model driving scan pins, programming voltage and two-wire data
// Assumes: tck runs only inside frames, 30 ns period
// Notes: words go out LSB first; callers reverse them for MSB-first use
`timescale 1ns/1ps
module jap_host_model
   import jap_pkg::*;
(
   output logic                       tck,
   output wire jap_pkg::jap_scan_in_s scanIn,
   output logic                       vppSettled,
   output logic                       twoWireData,
   input  wire logic                  tdoOut,
   input  wire logic                  tdoOe
);
   logic tmsBit, dBit, viaTdo;
   // data pin may carry the voltage, so the bit moves to the tdo pin
   assign scanIn = '{tms: tmsBit, tdi: viaTdo ? ~dBit : dBit, tdoIn: viaTdo ? dBit : (tdoOe ? tdoOut : ~dBit)};
   initial begin
      tck = 1'b0;
      tmsBit = 1'b1;
      dBit = 1'b0;
      viaTdo = 1'b0;
      vppSettled = 1'b0;
      twoWireData = 1'b0;
   end
   task automatic bit1(input logic m, input logic d, output logic q);
      tmsBit = m;
      dBit = d;
      #15 tck = 1'b1;
      q = tdoOut;
      #15 tck = 1'b0;
   endtask : bit1
   task automatic tapReset();
      logic q;
      repeat (5) bit1(1'b1, 1'b0, q);
      bit1(1'b0, 1'b0, q);
   endtask : tapReset
   task automatic shift(input logic isIr, input int n, input logic [15:0] d, output logic [15:0] q);
      logic x;
      q = 16'h0000;
      bit1(1'b1, 1'b0, x);
      if (isIr)
         bit1(1'b1, 1'b0, x);
      bit1(1'b0, 1'b0, x);
      bit1(1'b0, 1'b0, x);
      for (int i = 0; i < n; i++)
         bit1(i == n - 1, d[i], q[i]);
      bit1(1'b1, 1'b0, x);
      bit1(1'b0, 1'b0, x);
   endtask : shift
   task automatic burnArm(input logic twoWire);
      logic [15:0] q;
      if (!twoWire) begin
         shift(1'b1, IR_W, {8'h00, INSTR_CTRL_SELECT}, q);
         shift(1'b0, DR_W, CTRL_TDO_AS_TDI, q);
         viaTdo = 1'b1;
      end
      shift(1'b1, IR_W, {8'h00, INSTR_FUSE_PREPARE}, q);
      #1000000;
      vppSettled = !twoWire;
   endtask : burnArm
   task automatic burnFire(input logic twoWire);
      logic [15:0] q;
      logic x;
      shift(1'b1, IR_W, {8'h00, INSTR_FUSE_FIRE}, q);
      if (twoWire) begin
         bit1(1'b0, 1'b0, x);
         vppSettled = 1'b1;
      end
   endtask : burnFire
   task automatic dataHigh();
      #1000 twoWireData = 1'b1;
   endtask : dataHigh
   task automatic burnEnd();
      #1000000;
      vppSettled = 1'b0;
      twoWireData = 1'b0;
      viaTdo = 1'b0;
      tapReset();
   endtask : burnEnd
endmodule : jap_host_model

// ===== tb/tb_jap_access_protect.sv
// Purpose: self-checking bench of the access protection block
// Assumes: the host model owns the scan pins, voltage and two-wire data
// Notes: expectations queue up and a watcher process compares them
`timescale 1ns/1ps
module tb_jap_access_protect;
   import jap_pkg::*;
   typedef struct {string what; int sel; logic [15:0] exp;} jap_note_s;
   logic         sysClk = 1'b0, resetN = 1'b0, scanEnable = 1'b1, twoWireMode = 1'b0, fuseIntact = 1'b1;
   logic         protectedMode = 1'b0, passwordOk = 1'b0;
   logic [31:0]  lockWord = '0, secureWord = '0, r;
   logic [15:0]  lastWord = 16'h0000, d;
   logic         tck, vppSettled, twoWireData, tdoOut, tdoOe, fuseBlow, brownoutReset, scanLocked;
   jap_scan_in_s scanIn;
   integer       seed = 32'h0C4D9019;
   int           nErrors = 0, testsRun = 0;
   jap_note_s    noteQ[$];
   event         noteEv;
   always #50 sysClk = ~sysClk;
   jap_access_protect uut (.sys_clk(sysClk), .resetn(resetN), .*);
   jap_host_model host (.*);
   function automatic logic [15:0] seen(int sel);
      case (sel)
         0: return {15'h0000, scanLocked};
         1: return {15'h0000, fuseBlow};
         2: return {15'h0000, tdoOe};
         3: return {15'h0000, brownoutReset};
         default: return lastWord;
      endcase
   endfunction : seen
   task automatic check(string what, logic [15:0] got, logic [15:0] exp);
      testsRun++;
      if (got !== exp) begin
         nErrors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic closeOut();
      $display("checks %0d mismatches %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : closeOut
   task automatic note(string what, int sel, logic [15:0] exp);
      noteQ.push_back('{what, sel, exp});
      -> noteEv;
      #1;
   endtask : note
   always @(noteEv) begin
      jap_note_s n;
      while (noteQ.size() > 0) begin
         n = noteQ.pop_front();
         check(n.what, seen(n.sel), n.exp);
      end
   end
   task automatic cyc(int n);
      repeat (n) @(posedge sysClk);
      #5;
   endtask : cyc
   task automatic waitFor(int sel, logic [15:0] val, int limit);
      int i;
      for (i = 0; i < limit && seen(sel) !== val; i++)
         cyc(1);
      if (i == limit) begin
         nErrors++;
         $display("MISMATCH wait %0d expected %h seen %h", sel, val, seen(sel));
         closeOut();
      end
   endtask : waitFor
   task automatic boot();
      resetN = 1'b0;
      host.tapReset();
      cyc(6);
      resetN = 1'b1;
      cyc(4);
      host.tapReset();
   endtask : boot
   task automatic sh(logic isIr, logic [15:0] v);
      host.shift(isIr, isIr ? IR_W : DR_W, v, lastWord);
   endtask : sh
   initial begin
      r = 32'($random(seed));
      r = {r[31:1], 1'b0} | 32'h0000_0002;
      d = 16'($random(seed));
      for (int k = 0; k < 5; k++) begin
         lockWord = (k == 1) ? LOCK_ALL_ONE : (k == 2) ? r : LOCK_ALL_ZERO;
         secureWord = (k == 3) ? SECURE_PATTERN : 32'h0000_0000;
         fuseIntact = (k != 4);
         boot();
         note("boot lock", 0, {15'h0000, k >= 2});
      end
      $display("test boot done");
      sh(1'b1, {8'h00, INSTR_CTRL_SELECT});
      sh(1'b0, d);
      note("bypass word", 4, {d[14:0], 1'b0});
      host.tapReset();
      sh(1'b1, {8'h00, INSTR_CTRL_CAPTURE});
      sh(1'b0, {<<{16'hAAAA}});
      lastWord = {<<{lastWord}};
      note("protect probe", 4, 16'h5555);
      sh(1'b1, {8'h00, INSTR_BOR_TRIGGER});
      sh(1'b0, d);
      cyc(10);
      note("locked brownout", 3, 16'h0000);
      $display("test bypass done");
      fuseIntact = 1'b1;
      lockWord = LOCK_ALL_ZERO;
      boot();
      lockWord = r;
      cyc(20);
      note("live lock word", 0, 16'h0000);
      sh(1'b1, {8'h00, INSTR_BOR_TRIGGER});
      sh(1'b0, d);
      waitFor(3, 16'h0001, 20);
      note("scan released", 2, 16'h0000);
      waitFor(0, 16'h0001, 20);
      note("lock after brownout", 0, 16'h0001);
      $display("test brownout done");
      lockWord = LOCK_ALL_ZERO;
      boot();
      protectedMode = 1'b1;
      cyc(4);
      note("password refused", 0, 16'h0001);
      passwordOk = 1'b1;
      cyc(4);
      note("password taken", 0, 16'h0000);
      protectedMode = 1'b0;
      scanEnable = 1'b0;
      host.tapReset();
      note("enable low", 2, 16'h0000);
      scanEnable = 1'b1;
      host.tapReset();
      $display("test gates done");
      for (int w = 0; w < 2; w++) begin
         twoWireMode = w[0];
         host.burnArm(w[0]);
         if (w == 0)
            note("swap releases tdo", 2, 16'h0000);
         host.burnFire(w[0]);
         cyc(10);
         if (w == 1) begin
            note("no blow before data edge", 1, 16'h0000);
            host.dataHigh();
         end
         waitFor(1, 16'h0001, 20);
         note("fuse blow", 1, 16'h0001);
         host.burnEnd();
         cyc(5);
         note("fuse idle", 1, 16'h0000);
      end
      $display("test burn done");
      closeOut();
   end
endmodule : tb_jap_access_protect
